/* src/stored_program_sequencer.sv */
`timescale 1ns/1ps
module stored_program_sequencer
	import seq_pkg::*;
#(
	parameter int QUEUE_LINES = QUEUE_LINES_DEF,
	parameter int STACK_DEPTH = STACK_DEPTH_DEF
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic cmd_valid,
	input cmd_t cmd,
	output logic cmd_ready,
	output logic cmd_refused,
	input wire logic [31:0] stored_key,
	output logic nv_req,
	output nv_req_t nv_out,
	input wire logic nv_ack,
	input line_t nv_rdata,
	output logic exec_valid,
	output line_t exec_line,
	input wire logic exec_ready,
	output logic up_valid,
	output line_t up_line,
	input wire logic up_ready,
	output logic running,
	output logic locked
);
	if (QUEUE_LINES < 1 || QUEUE_LINES > 63 || STACK_DEPTH < 1 || STACK_DEPTH > 7) begin : g_bad
		$error("unsupported queue or stack size");
	end

	typedef enum {ST_IDLE, ST_LOAD, ST_STORE, ST_NV_OP, ST_UPLOAD, ST_RUN} state_t;
	localparam logic [5:0] LAST_LINE = 6'(QUEUE_LINES);
	localparam logic [2:0] MAX_DEPTH = 3'(STACK_DEPTH);

	state_t state, next_state;
	logic [5:0] pc, next_pc, q_len, next_q_len, idx, next_idx, resume_line, next_resume_line;
	logic [3:0] cur_seg, next_cur_seg;
	logic [2:0] depth, next_depth;
	frame_t [STACK_DEPTH-1:0] stack, next_stack;
	logic filling, next_filling, loaded, next_loaded, run_after, next_run_after;
	logic init_done, next_init_done, next_locked, next_cmd_ready, next_refused;
	logic [31:0] pending_key, next_pending_key;
	logic next_nv_req, next_exec_valid, next_up_valid;
	nv_req_t next_nv_out;
	line_t next_exec_line, next_up_line;
	line_t q_mem [QUEUE_LINES];
	logic q_we;
	logic [5:0] q_waddr;
	line_t q_wdata;
	logic acc, step, pval;
	line_t cl, rl;

	assign acc = cmd_valid && cmd_ready;
	assign rl = cmd.line;
	assign pval = seg_valid(rl.param);
	assign step = state == ST_RUN && !acc && !exec_valid && pc != 6'h00 && pc <= q_len;
	assign cl = q_mem[pc - FIRST_LINE];

	always_comb begin
		next_state = state;
		next_pc = pc;
		next_q_len = q_len;
		next_idx = idx;
		next_resume_line = resume_line;
		next_cur_seg = cur_seg;
		next_depth = depth;
		next_stack = stack;
		next_filling = filling;
		next_loaded = loaded;
		next_run_after = run_after;
		next_init_done = 1'b1;
		next_locked = locked;
		next_refused = 1'b0;
		next_pending_key = pending_key;
		next_nv_req = nv_req && !nv_ack;
		next_nv_out = nv_out;
		next_exec_valid = exec_valid && !exec_ready;
		next_exec_line = exec_line;
		next_up_valid = up_valid && !up_ready;
		next_up_line = up_line;
		q_we = 1'b0;
		q_waddr = idx;
		q_wdata = nv_rdata;
		if (!init_done) begin
			// Catching the stored key after release keeps the reset path constant.
			next_locked = stored_key != DEFAULT_KEY;
		end
		if (acc) begin
			unique case (rl.op)
				OP_KEY_CODE_ENTRY: begin
					if (locked) begin
						if (cmd.key == stored_key) begin
							next_locked = 1'b0;
						end else if (cmd.key == DEFAULT_KEY) begin
							next_locked = 1'b0;
							next_nv_out.kind = NV_ERASE_ALL;
							next_nv_req = 1'b1;
							next_state = ST_NV_OP;
						end else begin
							next_refused = 1'b1;
						end
					end else begin
						// Only staged here; the lock flag is set only after reset, from stored_key.
						next_pending_key = cmd.key;
					end
				end
				OP_SAVE_SETTINGS: begin
					next_nv_out.kind = NV_WRITE_KEY;
					next_nv_out.key = pending_key;
					next_nv_req = 1'b1;
					next_state = ST_NV_OP;
				end
				OP_PROGRAM_UPLOAD: begin
					if (locked) begin
						next_refused = 1'b1;
					end else begin
						next_idx = 6'h00;
						next_state = ST_UPLOAD;
					end
				end
				OP_SEGMENT_STORE: begin
					if (locked || !pval) begin
						next_refused = 1'b1;
					end else begin
						next_filling = 1'b0;
						next_idx = 6'h00;
						next_nv_out.seg = rl.param[3:0];
						next_state = ST_STORE;
					end
				end
				OP_SEGMENT_DELETE: begin
					if (locked || !pval) begin
						next_refused = 1'b1;
					end else begin
						next_nv_out.kind = NV_ERASE_SEG;
						next_nv_out.seg = rl.param[3:0];
						next_nv_req = 1'b1;
						next_state = ST_NV_OP;
					end
				end
				OP_QUEUE_FILL, OP_SEGMENT_FETCH: begin
					if (rl.has_param && pval) begin
						next_filling = 1'b0;
						next_idx = 6'h00;
						next_run_after = 1'b0;
						next_cur_seg = rl.param[3:0];
						next_nv_out.seg = rl.param[3:0];
						next_state = ST_LOAD;
					end else if (!rl.has_param && rl.op == OP_QUEUE_FILL) begin
						next_filling = 1'b1;
						next_q_len = 6'h00;
						next_loaded = 1'b0;
						next_cur_seg = 4'h0;
						next_state = ST_IDLE;
					end else begin
						next_refused = 1'b1;
					end
				end
				OP_QUEUE_RUN: begin
					if (loaded) begin
						next_filling = 1'b0;
						next_pc = FIRST_LINE;
						next_depth = 3'h0;
						next_state = ST_RUN;
					end else begin
						next_refused = 1'b1;
					end
				end
				default: begin
					if (filling && q_len < LAST_LINE) begin
						q_we = 1'b1;
						q_waddr = q_len;
						q_wdata = rl;
						next_q_len = q_len + 6'h01;
						next_loaded = 1'b1;
					end else if (rl.op == OP_QUEUE_HALT && state == ST_RUN) begin
						next_state = ST_IDLE;
					end else begin
						next_refused = 1'b1;
					end
				end
			endcase
		end
		if (step) begin
			next_pc = pc + 6'h01;
			unique case (cl.op)
				OP_SEGMENT_CALL: begin
					if (cl.has_param) begin
						if (seg_valid(cl.param) && depth < MAX_DEPTH) begin
							next_stack[depth] = '{seg: cur_seg, line: pc};
							next_depth = depth + 3'h1;
							next_cur_seg = cl.param[3:0];
							next_nv_out.seg = cl.param[3:0];
							next_resume_line = FIRST_LINE;
							next_run_after = 1'b1;
							next_idx = 6'h00;
							next_state = ST_LOAD;
						end
					end else if (depth != 3'h0) begin
						next_depth = depth - 3'h1;
						next_cur_seg = stack[depth - 3'h1].seg;
						next_nv_out.seg = stack[depth - 3'h1].seg;
						next_resume_line = stack[depth - 3'h1].line + 6'h01;
						next_run_after = 1'b1;
						next_idx = 6'h00;
						next_state = ST_LOAD;
					end
				end
				OP_LINE_JUMP: begin
					if (cl.has_param && cl.param != {2'b00, pc} && cl.param != 8'h00
							&& cl.param <= {2'b00, q_len}) begin
						next_pc = cl.param[5:0];
					end
				end
				OP_QUEUE_HALT: next_state = ST_IDLE;
				default: begin
					next_exec_valid = 1'b1;
					next_exec_line = cl;
				end
			endcase
		end else if (state == ST_RUN && !acc && !exec_valid) begin
			next_state = ST_IDLE;
		end
		unique case (state)
			ST_LOAD: begin
				if (!nv_req && !nv_ack) begin
					next_nv_req = 1'b1;
					next_nv_out.kind = NV_READ;
					next_nv_out.line = idx + FIRST_LINE;
				end
				if (nv_ack) begin
					if (nv_rdata.op != OP_NONE) begin
						q_we = 1'b1;
						next_idx = idx + 6'h01;
					end
					if (nv_rdata.op == OP_NONE || idx + 6'h01 == LAST_LINE) begin
						next_q_len = nv_rdata.op == OP_NONE ? idx : LAST_LINE;
						next_loaded = 1'b1;
						next_pc = resume_line;
						next_state = run_after ? ST_RUN : ST_IDLE;
					end
				end
			end
			ST_STORE: begin
				if (!nv_req && !nv_ack) begin
					next_nv_req = 1'b1;
					next_nv_out.kind = NV_WRITE;
					next_nv_out.line = idx + FIRST_LINE;
					next_nv_out.wdata = idx < q_len ? q_mem[idx] : '0;
				end
				if (nv_ack) begin
					next_idx = idx + 6'h01;
					if (idx >= q_len || idx + 6'h01 == LAST_LINE) begin
						next_state = ST_IDLE;
					end
				end
			end
			ST_NV_OP: begin
				if (nv_ack) begin
					next_state = ST_IDLE;
				end
			end
			ST_UPLOAD: begin
				if (!up_valid || up_ready) begin
					if (idx < q_len) begin
						next_up_valid = 1'b1;
						next_up_line = q_mem[idx];
						next_idx = idx + 6'h01;
					end else begin
						next_state = ST_IDLE;
					end
				end
			end
			default: begin
			end
		endcase
		next_cmd_ready = next_state == ST_IDLE || next_state == ST_RUN;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state <= ST_IDLE;
			pc <= 6'h00;
			q_len <= 6'h00;
			idx <= 6'h00;
			resume_line <= 6'h00;
			cur_seg <= 4'h0;
			depth <= 3'h0;
			stack <= '0;
			filling <= 1'b0;
			loaded <= 1'b0;
			run_after <= 1'b0;
			init_done <= 1'b0;
			locked <= 1'b0;
			cmd_ready <= 1'b0;
			cmd_refused <= 1'b0;
			pending_key <= DEFAULT_KEY;
			nv_req <= 1'b0;
			nv_out <= '0;
			exec_valid <= 1'b0;
			exec_line <= '0;
			up_valid <= 1'b0;
			up_line <= '0;
			running <= 1'b0;
		end else begin
			state <= next_state;
			pc <= next_pc;
			q_len <= next_q_len;
			idx <= next_idx;
			resume_line <= next_resume_line;
			cur_seg <= next_cur_seg;
			depth <= next_depth;
			stack <= next_stack;
			filling <= next_filling;
			loaded <= next_loaded;
			run_after <= next_run_after;
			init_done <= next_init_done;
			locked <= next_locked;
			cmd_ready <= next_cmd_ready && init_done;
			cmd_refused <= next_refused;
			pending_key <= next_pending_key;
			nv_req <= next_nv_req;
			nv_out <= next_nv_out;
			exec_valid <= next_exec_valid;
			exec_line <= next_exec_line;
			up_valid <= next_up_valid;
			up_line <= next_up_line;
			running <= next_state == ST_RUN;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (q_we) begin
			q_mem[q_waddr] <= q_wdata;
		end
	end

	a_stack_bound: assert property (@(posedge sys_clk) disable iff (reset)
		depth <= MAX_DEPTH) else $error("call stack deeper than allowed");
	a_call_full: assert property (@(posedge sys_clk) disable iff (reset)
		step && cl.op == OP_SEGMENT_CALL && cl.has_param && depth == MAX_DEPTH
		|=> state == ST_RUN && pc == $past(pc) + 6'h01) else $error("full-stack call not ignored");
	a_call_push: assert property (@(posedge sys_clk) disable iff (reset)
		step && cl.op == OP_SEGMENT_CALL && cl.has_param && seg_valid(cl.param)
		&& depth < MAX_DEPTH
		|=> state == ST_LOAD && depth == $past(depth) + 3'h1 && resume_line == FIRST_LINE)
		else $error("call did not push and load");
	a_return_empty: assert property (@(posedge sys_clk) disable iff (reset)
		step && cl.op == OP_SEGMENT_CALL && !cl.has_param && depth == 3'h0
		|=> state == ST_RUN && pc == $past(pc) + 6'h01) else $error("empty return not ignored");
	a_jump_self: assert property (@(posedge sys_clk) disable iff (reset)
		step && cl.op == OP_LINE_JUMP && cl.param == {2'b00, pc}
		|=> pc == $past(pc) + 6'h01) else $error("jump to own line taken");
	a_lock_refuse: assert property (@(posedge sys_clk) disable iff (reset)
		acc && locked && (rl.op inside {OP_PROGRAM_UPLOAD, OP_SEGMENT_STORE, OP_SEGMENT_DELETE})
		|=> cmd_refused && !nv_req && !up_valid) else $error("protected command ran while locked");
	a_key_unlock: assert property (@(posedge sys_clk) disable iff (reset)
		acc && locked && rl.op == OP_KEY_CODE_ENTRY && cmd.key == stored_key
		|=> !locked && !cmd_refused) else $error("matching key did not unlock");
	a_default_erase: assert property (@(posedge sys_clk) disable iff (reset)
		acc && locked && rl.op == OP_KEY_CODE_ENTRY && cmd.key == DEFAULT_KEY && stored_key != DEFAULT_KEY
		|=> !locked && nv_req && nv_out.kind == NV_ERASE_ALL) else $error("default key did not erase");
	a_run_start: assert property (@(posedge sys_clk) disable iff (reset)
		acc && rl.op == OP_QUEUE_RUN && loaded |=> state == ST_RUN && pc == FIRST_LINE && running)
		else $error("queue run did not start at line one");
	a_delete_now: assert property (@(posedge sys_clk) disable iff (reset)
		acc && rl.op == OP_SEGMENT_DELETE && !locked && pval
		|=> nv_req && nv_out.kind == NV_ERASE_SEG && nv_out.seg == $past(rl.param[3:0]))
		else $error("delete not issued at once");
endmodule // stored_program_sequencer

/* src/seq_pkg.sv */
package seq_pkg;
	localparam int QUEUE_LINES_DEF = 62;
	localparam int STACK_DEPTH_DEF = 5;
	localparam int SEG_COUNT = 12;
	localparam logic [5:0] FIRST_LINE = 6'h01;
	localparam logic [31:0] DEFAULT_KEY = 32'h31323334;
	typedef enum logic [3:0] {
		OP_NONE,
		OP_MOTION,
		OP_SEGMENT_CALL,
		OP_LINE_JUMP,
		OP_QUEUE_HALT,
		OP_KEY_CODE_ENTRY,
		OP_SAVE_SETTINGS,
		OP_PROGRAM_UPLOAD,
		OP_SEGMENT_STORE,
		OP_SEGMENT_DELETE,
		OP_QUEUE_FILL,
		OP_SEGMENT_FETCH,
		OP_QUEUE_RUN
	} op_t;
	typedef struct packed {
		op_t op;
		logic has_param;
		logic [7:0] param;
	} line_t;
	typedef struct packed {
		line_t line;
		logic [31:0] key;
	} cmd_t;
	typedef enum logic [2:0] {NV_READ, NV_WRITE, NV_ERASE_SEG, NV_ERASE_ALL, NV_WRITE_KEY} nv_kind_t;
	typedef struct packed {
		nv_kind_t kind;
		logic [3:0] seg;
		logic [5:0] line;
		line_t wdata;
		logic [31:0] key;
	} nv_req_t;
	typedef struct packed {
		logic [3:0] seg;
		logic [5:0] line;
	} frame_t;
	function automatic logic seg_valid(input logic [7:0] p);
		return p >= 8'h01 && p <= 8'(SEG_COUNT);
	endfunction
endpackage

/* sim/nv_store_model.sv */
`timescale 1ns/1ps
module nv_store_model
	import seq_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic nv_req,
	input nv_req_t nv_out,
	input wire logic [3:0] delay,
	output logic nv_ack,
	output line_t nv_rdata
);
	line_t mem [1:12][1:62];
	nv_kind_t last_kind;
	logic [3:0] last_seg;
	logic [31:0] last_key;
	int wait_n;
	initial begin
		nv_ack = 1'b0;
		nv_rdata = '0;
		wait_n = 0;
		foreach (mem[s, l]) mem[s][l] = '0;
	end
	task automatic put(input int s, input int l, input line_t v);
		mem[s][l] = v;
	endtask
	always @(posedge sys_clk) begin
		nv_ack <= 1'b0;
		// Read data is only good beside the acknowledge, so it toggles meanwhile.
		nv_rdata <= ~nv_rdata;
		if (reset || nv_ack || !nv_req) begin
			wait_n <= 0;
		end else if (wait_n < int'(delay)) begin
			wait_n <= wait_n + 1;
		end else begin
			nv_ack <= 1'b1;
			last_kind <= nv_out.kind;
			last_seg <= nv_out.seg;
			case (nv_out.kind)
				NV_READ: nv_rdata <= mem[nv_out.seg][nv_out.line];
				NV_WRITE: mem[nv_out.seg][nv_out.line] <= nv_out.wdata;
				NV_ERASE_SEG: for (int l = 1; l <= 62; l++) mem[nv_out.seg][l] <= '0;
				NV_ERASE_ALL: foreach (mem[s, l]) mem[s][l] <= '0;
				default: last_key <= nv_out.key;
			endcase
		end
	end
endmodule // nv_store_model

/* sim/stored_program_sequencer_tb.sv */
`timescale 1ns/1ps
module stored_program_sequencer_tb
	import seq_pkg::*;
;
	localparam logic [31:0] LOCK_KEY = 32'h616b3939;
	logic sys_clk, reset, cmd_valid, cmd_ready, cmd_refused, nv_req, nv_ack, refused;
	logic exec_valid, exec_ready, up_valid, up_ready, running, locked;
	logic [31:0] stored_key, rs;
	logic [3:0] delay;
	cmd_t cmd;
	nv_req_t nv_out;
	line_t nv_rdata, exec_line, up_line;
	line_t got[$];
	line_t fill[$];
	line_t upq[$];
	int bad_count, n_tests;
	stored_program_sequencer stored_program_sequencer_i (.sys_clk(sys_clk), .reset(reset),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .cmd_refused(cmd_refused),
		.stored_key(stored_key), .nv_req(nv_req), .nv_out(nv_out), .nv_ack(nv_ack),
		.nv_rdata(nv_rdata), .exec_valid(exec_valid), .exec_line(exec_line),
		.exec_ready(exec_ready), .up_valid(up_valid), .up_line(up_line), .up_ready(up_ready),
		.running(running), .locked(locked));
	nv_store_model nv_store_model_i (.sys_clk(sys_clk), .reset(reset), .nv_req(nv_req),
		.nv_out(nv_out), .delay(delay), .nv_ack(nv_ack), .nv_rdata(nv_rdata));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	function automatic line_t mk(input op_t o, input logic h, input logic [7:0] p);
		return '{o, h, p};
	endfunction
	function automatic line_t mv(input logic [7:0] p);
		return mk(OP_MOTION, 1'b1, p);
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask
	task automatic send(input op_t op, input logic h, input logic [7:0] p, input logic [31:0] k);
		int n;
		n = 0;
		tick();
		cmd_valid = 1'b1;
		cmd = '{'{op, h, p}, k};
		while (cmd_ready !== 1'b1 && n < 5000) begin
			tick();
			n++;
		end
		tick();
		cmd_valid = 1'b0;
		refused = cmd_refused;
		if (n >= 5000) chk("cmd_ready", 1, 0);
	endtask
	task automatic settle();
		int n;
		n = 0;
		repeat (2) tick();
		// A line still waiting on the motion path would leak into the next run.
		while ((running !== 1'b0 || cmd_ready !== 1'b1 || exec_valid !== 1'b0) && n < 5000) begin
			tick();
			n++;
		end
		if (n >= 5000) chk("settle", 1, 0);
	endtask
	task automatic chk_run(input line_t exp[$], input logic whole);
		int n;
		n = 0;
		while (got.size() < exp.size() && n < 5000) begin
			tick();
			n++;
		end
		foreach (exp[i]) chk("exec_line", exp[i], got[i]);
		if (whole) begin
			settle();
			chk("exec count", exp.size(), got.size());
		end
		got.delete();
	endtask
	task automatic do_reset(input logic [31:0] k);
		reset = 1'b1;
		stored_key = k;
		repeat (20) @(posedge sys_clk);
		#1;
		reset = 1'b0;
		repeat (2) tick();
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Ready lines stall at random so held outputs are exercised.
	always @(posedge sys_clk) begin
		#1;
		rs = xs(rs);
		exec_ready = rs[1:0] != 2'b00;
		up_ready = rs[2];
		delay = rs[7:4];
	end
	always @(posedge sys_clk) begin
		if (exec_valid === 1'b1 && exec_ready === 1'b1) got.push_back(exec_line);
	end
	always @(posedge sys_clk) begin
		if (up_valid === 1'b1 && up_ready === 1'b1) upq.push_back(up_line);
	end
	initial begin
		#900000;
		bad_count++;
		end_sim();
	end
	initial begin
		reset = 1'b1;
		cmd_valid = 1'b0;
		cmd = '0;
		exec_ready = 1'b0;
		up_ready = 1'b0;
		delay = 4'h0;
		rs = 32'd94059;
		stored_key = DEFAULT_KEY;
		bad_count = 0;
		n_tests = 0;
		// The storage model clears itself at time zero, so contents go in after it.
		#1;
		nv_store_model_i.put(1, 1, mv(8'h11));
		nv_store_model_i.put(1, 2, mk(OP_SEGMENT_CALL, 1'b1, 8'h02));
		nv_store_model_i.put(1, 3, mk(OP_SEGMENT_CALL, 1'b0, 8'h00));
		nv_store_model_i.put(1, 4, mv(8'h14));
		nv_store_model_i.put(2, 1, mv(8'h21));
		nv_store_model_i.put(2, 2, mk(OP_SEGMENT_CALL, 1'b0, 8'h00));
		for (int s = 3; s <= 8; s++) nv_store_model_i.put(s, 1, mk(OP_SEGMENT_CALL, 1'b1, 8'(s + 1)));
		nv_store_model_i.put(8, 2, mv(8'h82));
		nv_store_model_i.put(9, 1, mv(8'h91));
		nv_store_model_i.put(10, 1, mv(8'ha1));
		nv_store_model_i.put(10, 2, mk(OP_LINE_JUMP, 1'b1, 8'h02));
		nv_store_model_i.put(10, 3, mk(OP_LINE_JUMP, 1'b1, 8'h05));
		nv_store_model_i.put(10, 4, mv(8'ha4));
		nv_store_model_i.put(10, 5, mv(8'ha5));
		nv_store_model_i.put(10, 6, mk(OP_LINE_JUMP, 1'b1, 8'd40));
		nv_store_model_i.put(10, 7, mv(8'ha7));
		nv_store_model_i.put(10, 8, mk(OP_LINE_JUMP, 1'b1, 8'h01));
		do_reset(DEFAULT_KEY);
		chk("locked", 0, locked);
		send(OP_QUEUE_RUN, 1'b0, 8'h00, 0);
		chk("refused", 1, refused);
		send(OP_SEGMENT_DELETE, 1'b1, 8'd13, 0);
		chk("refused", 1, refused);
		send(OP_SEGMENT_DELETE, 1'b1, 8'd11, 0);
		chk("refused", 0, refused);
		settle();
		chk("nv kind", NV_ERASE_SEG, nv_store_model_i.last_kind);
		chk("nv seg", 11, nv_store_model_i.last_seg);
		$display("test delete done");
		send(OP_SEGMENT_FETCH, 1'b1, 8'h01, 0);
		settle();
		send(OP_QUEUE_RUN, 1'b0, 8'h00, 0);
		chk_run('{mv(8'h11), mv(8'h21), mv(8'h14)}, 1'b1);
		$display("test call return done");
		send(OP_QUEUE_FILL, 1'b0, 8'h00, 0);
		for (int i = 0; i < 3; i++) begin
			fill.push_back(mv(rs[15:8]));
			send(OP_MOTION, 1'b1, fill[i].param, 0);
		end
		send(OP_SEGMENT_STORE, 1'b1, 8'd12, 0);
		settle();
		for (int i = 0; i < 3; i++) chk("stored", fill[i], nv_store_model_i.mem[12][i + 1]);
		chk("stored end", 0, nv_store_model_i.mem[12][4]);
		send(OP_SEGMENT_FETCH, 1'b1, 8'd12, 0);
		settle();
		send(OP_QUEUE_RUN, 1'b0, 8'h00, 0);
		chk_run(fill, 1'b1);
		send(OP_PROGRAM_UPLOAD, 1'b0, 8'h00, 0);
		chk("refused", 0, refused);
		settle();
		foreach (fill[i]) chk("up_line", fill[i], upq[i]);
		chk("up count", fill.size(), upq.size());
		$display("test fill store done");
		send(OP_QUEUE_FILL, 1'b1, 8'd10, 0);
		settle();
		for (int r = 0; r < 2; r++) begin
			send(OP_QUEUE_RUN, 1'b0, 8'h00, 0);
			chk_run('{mv(8'ha1), mv(8'ha5), mv(8'ha7), mv(8'ha1), mv(8'ha5), mv(8'ha7)}, 0);
			send(OP_QUEUE_HALT, 1'b0, 8'h00, 0);
			settle();
			chk("running", 0, running);
			got.delete();
		end
		$display("test jump halt done");
		send(OP_SEGMENT_FETCH, 1'b1, 8'h03, 0);
		settle();
		send(OP_QUEUE_RUN, 1'b0, 8'h00, 0);
		chk_run('{mv(8'h82)}, 1'b1);
		$display("test stack depth done");
		send(OP_KEY_CODE_ENTRY, 1'b0, 8'h00, LOCK_KEY);
		send(OP_SAVE_SETTINGS, 1'b0, 8'h00, 0);
		settle();
		chk("nv kind", NV_WRITE_KEY, nv_store_model_i.last_kind);
		chk("nv key", LOCK_KEY, nv_store_model_i.last_key);
		chk("locked", 0, locked);
		$display("test key save done");
		do_reset(LOCK_KEY);
		chk("locked", 1, locked);
		send(OP_SEGMENT_DELETE, 1'b1, 8'h05, 0);
		chk("refused", 1, refused);
		send(OP_PROGRAM_UPLOAD, 1'b0, 8'h00, 0);
		chk("refused", 1, refused);
		send(OP_SEGMENT_STORE, 1'b1, 8'h05, 0);
		chk("refused", 1, refused);
		send(OP_SEGMENT_FETCH, 1'b1, 8'h01, 0);
		chk("refused", 0, refused);
		settle();
		send(OP_QUEUE_RUN, 1'b0, 8'h00, 0);
		chk_run('{mv(8'h11), mv(8'h21), mv(8'h14)}, 1'b1);
		send(OP_KEY_CODE_ENTRY, 1'b0, 8'h00, 32'h41424344);
		chk("refused", 1, refused);
		send(OP_KEY_CODE_ENTRY, 1'b0, 8'h00, LOCK_KEY);
		settle();
		chk("locked", 0, locked);
		send(OP_SEGMENT_DELETE, 1'b1, 8'h05, 0);
		settle();
		chk("nv seg", 5, nv_store_model_i.last_seg);
		chk("erased", 0, nv_store_model_i.mem[5][1]);
		do_reset(LOCK_KEY);
		chk("locked", 1, locked);
		send(OP_KEY_CODE_ENTRY, 1'b0, 8'h00, DEFAULT_KEY);
		settle();
		chk("locked", 0, locked);
		chk("nv kind", NV_ERASE_ALL, nv_store_model_i.last_kind);
		chk("erased all", 0, nv_store_model_i.mem[1][1]);
		$display("test lock done");
		end_sim();
	end
endmodule // stored_program_sequencer_tb
